/* design/dpf_debug_pin_select.sv */
`default_nettype none

module dpf_debug_pin_select
  import dpf_pkg::*;
(
  input  wire logic                 i_sys_clk,            // System clock, 100 MHz
  input  wire logic                 i_srst,               // Synchronous reset, high
  input  wire dpf_pkg::dpf_pin_in_s i_pin,                // Raw connector pin levels
  input  wire logic                 i_scan_tdo,           // Scan data out from core
  input  wire logic                 i_scan_tdo_en,        // Core shifting, drive data out
  input  wire logic                 i_serial_tx,          // Serial transmit from core
  input  wire logic                 i_cpu_overheat,       // Processor overheat event
  output logic                      o_tdo_or_tx_out,      // Shared pin 1 output level
  output logic                      o_tdo_or_tx_oe,       // Shared pin 1 drive enable
  output dpf_pkg::dpf_mode_e        o_mode,               // Current function mode
  output dpf_pkg::dpf_scan_s        o_scan,               // Scan signals to core
  output dpf_pkg::dpf_alt_s         o_alt,                // Secondary signals to core
  output logic                      o_throttle_req,       // Thermal throttling request
  output logic                      o_alarm_event,        // One pulse on alarm onset
  output logic                      o_thermal_trip_n,     // Thermal trip pin, low active
  output logic                      o_soft_off_req        // Soft-off request to power control
);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  dpf_pin_in_s meta_ff;                                   // First stage, read by sync_ff only
  dpf_pin_in_s sync_ff;                                   // Second stage, safe to use
  dpf_mode_e   nxt_mode;                                  // Mode from synced select
  logic        alarm_prev_ff;                             // Last synced alarm level
  logic        trip_ff;                                   // Sticky trip state
  logic [1:0]  rst_age_ff;                                // Cycles since reset, checks only

  // Pins are asynchronous to the core clock; two flops stop metastability
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      meta_ff <= DPF_PIN_IN_RST;
      sync_ff <= DPF_PIN_IN_RST;
    end else begin
      meta_ff <= i_pin;
      sync_ff <= meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Pure decode of the select level, no hysteresis or switch delay
  always_comb begin
    nxt_mode = sync_ff.function_select ? DPF_MODE_SCAN : DPF_MODE_SERIAL;
  end

  // Mode register
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_mode <= DPF_MODE_SCAN;
    end else begin
      o_mode <= nxt_mode;
    end
  end

  // ----------------------------------------------------------------
  // Input routing
  // ----------------------------------------------------------------
  // Unselected side sees idle levels so its logic never sees stray edges
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_scan <= DPF_SCAN_IDLE;
      o_alt  <= DPF_ALT_IDLE;
    end else begin
      unique case (nxt_mode)
        DPF_MODE_SCAN: begin                              // Boundary scan use
          o_scan.tck <= sync_ff.clock_or_vendor_ctl;
          o_scan.tdi <= sync_ff.tdi_or_serial_rx;
          o_scan.tms <= sync_ff.tms_or_boot;
          o_alt      <= DPF_ALT_IDLE;
        end
        DPF_MODE_SERIAL: begin                            // Secondary use
          o_scan           <= DPF_SCAN_IDLE;
          o_alt.serial_rx  <= sync_ff.tdi_or_serial_rx;
          o_alt.boot       <= sync_ff.tms_or_boot;
          o_alt.vendor_ctl <= sync_ff.clock_or_vendor_ctl;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output routing, shared pin 1
  // ----------------------------------------------------------------
  // Data out drives only while shifting; serial transmit always drives
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_tdo_or_tx_out <= DPF_TX_PIN_RST;
      o_tdo_or_tx_oe  <= DPF_TX_OE_RST;
    end else begin
      unique case (nxt_mode)
        DPF_MODE_SCAN: begin                              // Scan data out
          o_tdo_or_tx_out <= i_scan_tdo;
          o_tdo_or_tx_oe  <= i_scan_tdo_en;
        end
        DPF_MODE_SERIAL: begin                            // Serial transmit
          o_tdo_or_tx_out <= i_serial_tx;
          o_tdo_or_tx_oe  <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Thermal alarm
  // ----------------------------------------------------------------
  // Throttle follows the level; the pulse marks each new onset
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      alarm_prev_ff  <= 1'b1;
      o_throttle_req <= 1'b0;
      o_alarm_event  <= 1'b0;
    end else begin
      alarm_prev_ff  <= sync_ff.thermal_alarm_n;
      o_throttle_req <= ~sync_ff.thermal_alarm_n;
      o_alarm_event  <= alarm_prev_ff & ~sync_ff.thermal_alarm_n;
    end
  end

  // ----------------------------------------------------------------
  // Thermal trip
  // ----------------------------------------------------------------
  // Sticky until reset: a cooled processor must not wake itself
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      trip_ff <= 1'b0;
    end else if (i_cpu_overheat) begin
      trip_ff <= 1'b1;
    end
  end

  // Trip outputs assert the cycle after the overheat event
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_thermal_trip_n <= DPF_TRIP_N_RST;
      o_soft_off_req   <= 1'b0;
    end else begin
      o_thermal_trip_n <= ~(trip_ff | i_cpu_overheat);
      o_soft_off_req   <= trip_ff | i_cpu_overheat;
    end
  end

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------
  // Counts cycles since reset so pin history is trusted only when live
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rst_age_ff <= 2'h0;
    end else if (rst_age_ff != DPF_RST_AGE_MAX) begin
      rst_age_ff <= rst_age_ff + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_mode_follow;
    @(posedge i_sys_clk) disable iff (i_srst)
      (rst_age_ff == DPF_RST_AGE_MAX) |-> ((o_mode == DPF_MODE_SCAN) == $past(i_pin.function_select, 3));
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("mode not following select");

  property p_scan_inputs;
    @(posedge i_sys_clk) disable iff (i_srst)
      (rst_age_ff == DPF_RST_AGE_MAX && o_mode == DPF_MODE_SCAN)
        |-> (o_scan.tck == $past(i_pin.clock_or_vendor_ctl, 3) && o_scan.tms == $past(i_pin.tms_or_boot, 3)
             && o_scan.tdi == $past(i_pin.tdi_or_serial_rx, 3));
  endproperty
  a_scan_inputs: assert property (p_scan_inputs) else $error("scan inputs misrouted");

  property p_serial_scan_idle;
    @(posedge i_sys_clk) disable iff (i_srst)
      (o_mode == DPF_MODE_SERIAL) |-> (o_scan == DPF_SCAN_IDLE);
  endproperty
  a_serial_scan_idle: assert property (p_serial_scan_idle) else $error("scan active in secondary mode");

  property p_tx_pin;
    @(posedge i_sys_clk) disable iff (i_srst)
      (nxt_mode == DPF_MODE_SERIAL) |=> (o_tdo_or_tx_oe && o_tdo_or_tx_out == $past(i_serial_tx));
  endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("transmit not on pin 1");

  property p_tdo_pin;
    @(posedge i_sys_clk) disable iff (i_srst)
      (nxt_mode == DPF_MODE_SCAN) |=> (o_tdo_or_tx_oe == $past(i_scan_tdo_en) && o_tdo_or_tx_out == $past(i_scan_tdo));
  endproperty
  a_tdo_pin: assert property (p_tdo_pin) else $error("scan data out not on pin 1");

  property p_rx_route;
    @(posedge i_sys_clk) disable iff (i_srst)
      (rst_age_ff == DPF_RST_AGE_MAX && o_mode == DPF_MODE_SERIAL)
        |-> (o_alt.serial_rx == $past(i_pin.tdi_or_serial_rx, 3));
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("receive misrouted");

  property p_boot_route;
    @(posedge i_sys_clk) disable iff (i_srst)
      (rst_age_ff == DPF_RST_AGE_MAX && o_mode == DPF_MODE_SERIAL) |-> (o_alt.boot == $past(i_pin.tms_or_boot, 3));
  endproperty
  a_boot_route: assert property (p_boot_route) else $error("boot signal misrouted");

  property p_vendor_gated;
    @(posedge i_sys_clk) disable iff (i_srst)
      (o_mode == DPF_MODE_SCAN) |-> (o_alt == DPF_ALT_IDLE);
  endproperty
  a_vendor_gated: assert property (p_vendor_gated) else $error("secondary signals leak in scan mode");

  property p_vendor_route;
    @(posedge i_sys_clk) disable iff (i_srst)
      (rst_age_ff == DPF_RST_AGE_MAX && o_mode == DPF_MODE_SERIAL)
        |-> (o_alt.vendor_ctl == $past(i_pin.clock_or_vendor_ctl, 3));
  endproperty
  a_vendor_route: assert property (p_vendor_route) else $error("vendor control misrouted");

  property p_throttle;
    @(posedge i_sys_clk) disable iff (i_srst)
      (rst_age_ff == DPF_RST_AGE_MAX) |-> (o_throttle_req == !$past(i_pin.thermal_alarm_n, 3));
  endproperty
  a_throttle: assert property (p_throttle) else $error("throttle not tied to alarm");

  property p_alarm_pulse;
    @(posedge i_sys_clk) disable iff (i_srst)
      o_alarm_event |=> !o_alarm_event;
  endproperty
  a_alarm_pulse: assert property (p_alarm_pulse) else $error("alarm event longer than one cycle");

  property p_trip_now;
    @(posedge i_sys_clk) disable iff (i_srst)
      i_cpu_overheat |=> (!o_thermal_trip_n && o_soft_off_req);
  endproperty
  a_trip_now: assert property (p_trip_now) else $error("trip late after overheat");

  property p_trip_sticky;
    @(posedge i_sys_clk) disable iff (i_srst)
      !o_thermal_trip_n |=> (!o_thermal_trip_n && o_soft_off_req) [*4];
  endproperty
  a_trip_sticky: assert property (p_trip_sticky) else $error("trip released before reset");

endmodule

`default_nettype wire

/* design/dpf_pkg.sv */
`default_nettype none

package dpf_pkg;

  // ----------------------------------------------------------------
  // Function modes
  // ----------------------------------------------------------------
  typedef enum logic {
    DPF_MODE_SERIAL,                         // Select low: serial, boot, vendor control
    DPF_MODE_SCAN                            // Select high: boundary scan
  } dpf_mode_e;

  // ----------------------------------------------------------------
  // Pin-side bundles
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clock_or_vendor_ctl;               // Shared pin 0 level
    logic tdi_or_serial_rx;                  // Shared pin 2 level
    logic tms_or_boot;                       // Shared pin 3 level
    logic function_select;                   // Select pin level
    logic thermal_alarm_n;                   // Thermal alarm, low active
  } dpf_pin_in_s;

  // Core-side boundary scan inputs
  typedef struct packed {
    logic tck;                               // Scan clock level
    logic tdi;                               // Scan data in
    logic tms;                               // Scan mode select
  } dpf_scan_s;

  // Core-side secondary inputs
  typedef struct packed {
    logic serial_rx;                         // Serial receive line
    logic boot;                              // Vendor boot signal
    logic vendor_ctl;                        // Vendor control signal
  } dpf_alt_s;

  // ----------------------------------------------------------------
  // Reset and idle values
  // ----------------------------------------------------------------
  localparam int          DPF_SYNC_STAGES   = 2;                 // Flops per pin input
  localparam int          DPF_PIN_LATENCY   = 3;                 // Pin to core output, cycles
  localparam dpf_pin_in_s DPF_PIN_IN_RST    = 5'h1F;             // Pins idle high, select high
  localparam dpf_scan_s   DPF_SCAN_IDLE     = 3'h3;              // Tck low, tdi and tms high
  localparam dpf_alt_s    DPF_ALT_IDLE      = 3'h4;              // Rx idle high, boot and ctl low
  localparam logic        DPF_TX_PIN_RST    = 1'h1;              // Transmit pin idles high
  localparam logic        DPF_TX_OE_RST     = 1'h0;              // Pin released in reset
  localparam logic        DPF_TRIP_N_RST    = 1'h1;              // Trip inactive in reset
  localparam logic [1:0]  DPF_RST_AGE_MAX   = 2'h3;              // Age at which pipeline is live

endpackage

`default_nettype wire

/* tb/dpf_carrier_model.sv */
`default_nettype none

module dpf_carrier_model
  import dpf_pkg::*;
(
  input  wire logic                i_sys_clk,  // Bench clock
  input  wire logic                i_tx_out,   // Pin 1 level from device
  input  wire logic                i_tx_oe,    // Pin 1 drive enable
  output var dpf_pkg::dpf_pin_in_s o_pin,      // Levels at the connector
  output logic                     o_tx_wire   // Resolved pin 1 wire
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_ff;                             // Last level driven on pin 1

  // ----------------------------------------
  // Carrier-side pin drivers
  // ----------------------------------------
  // Idle high until the bench asks otherwise
  initial begin
    o_pin   = DPF_PIN_IN_RST;
    last_ff = 1'b0;
  end

  // Change all pins just after a rising edge
  task automatic drive(input dpf_pin_in_s v);
    @(posedge i_sys_clk);
    o_pin <= v;
  endtask

  // ----------------------------------------
  // Pin 1 wire
  // ----------------------------------------
  // No pull on this pin, so a released wire must not look valid
  always @(posedge i_sys_clk) begin
    if (i_tx_oe) begin
      last_ff <= i_tx_out;
    end
  end
  assign o_tx_wire = i_tx_oe ? i_tx_out : ~last_ff;

endmodule

`default_nettype wire

/* tb/tb.sv */
`default_nettype none

module tb
  import dpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals and scoreboard
  // ----------------------------------------
  typedef struct {
    int         due;                         // Negedge count to look at
    int         sel;                         // Which output
    logic [7:0] exp;                         // Expected value
  } dpf_note_s;

  logic        sys_clk, srst, scan_tdo, scan_tdo_en, serial_tx, cpu_overheat;
  dpf_pin_in_s pin, p;
  logic        tx_out, tx_oe, throttle, alarm_ev, trip_n, soft_off, tx_wire, prev_n, last_drv;
  dpf_mode_e   mode;
  dpf_scan_s   scan;
  dpf_alt_s    alt;
  dpf_note_s   q[$], n;
  int          neg_cnt, error_cnt, tests_run;
  logic [2:0]  r;

  dpf_carrier_model carrier_u (.i_sys_clk(sys_clk), .i_tx_out(tx_out), .i_tx_oe(tx_oe),
                               .o_pin(pin), .o_tx_wire(tx_wire));

  dpf_debug_pin_select dut_u (
    .i_sys_clk(sys_clk), .i_srst(srst), .i_pin(pin), .i_scan_tdo(scan_tdo),
    .i_scan_tdo_en(scan_tdo_en), .i_serial_tx(serial_tx), .i_cpu_overheat(cpu_overheat),
    .o_tdo_or_tx_out(tx_out), .o_tdo_or_tx_oe(tx_oe), .o_mode(mode), .o_scan(scan),
    .o_alt(alt), .o_throttle_req(throttle), .o_alarm_event(alarm_ev),
    .o_thermal_trip_n(trip_n), .o_soft_off_req(soft_off));

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Note a result due lat edges after the edge just passed
  task automatic push(input int sel, input logic [7:0] v, input int lat);
    q.push_back('{neg_cnt + 1 + lat, sel, v});
  endtask

  // Let every pending note drain before the next test
  task automatic end_test(input string name);
    repeat (6) @(posedge sys_clk);
    $display("test %s done", name);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Outputs settle well before the falling edge
  always @(negedge sys_clk) begin
    neg_cnt = neg_cnt + 1;
    while (q.size() > 0 && q[0].due <= neg_cnt) begin
      n = q.pop_front();
      case (n.sel)
        0: check("mode", {7'h0, mode}, n.exp);
        1: check("scan", {5'h0, scan}, n.exp);
        2: check("alt", {5'h0, alt}, n.exp);
        3: check("pin1", {6'h0, tx_out, tx_oe}, n.exp);
        4: check("throttle", {7'h0, throttle}, n.exp);
        5: check("alarm_event", {7'h0, alarm_ev}, n.exp);
        6: check("trip", {6'h0, trip_n, soft_off}, n.exp);
        default: check("pin1_wire", {7'h0, tx_wire}, n.exp);
      endcase
    end
  end

  // Hang guard, far beyond the roughly 140 cycles needed
  initial begin
    #50us;
    error_cnt++;
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {sys_clk, scan_tdo, scan_tdo_en, cpu_overheat} = '0;
    {srst, serial_tx, prev_n} = 3'h7;
    neg_cnt = 0;
    error_cnt = 0;
    tests_run = 0;
    void'($urandom(89));
    repeat (19) @(posedge sys_clk);
    push(0, 8'h1, 0);
    push(1, 8'h3, 0);
    push(2, 8'h4, 0);
    push(3, 8'h2, 0);
    push(6, 8'h2, 0);
    push(4, 8'h0, 0);
    push(5, 8'h0, 0);
    @(posedge sys_clk);
    srst <= 1'b0;
    end_test("reset");
    // Select and pins change every cycle, routing tracks each sample
    for (int i = 0; i < 40; i++) begin
      p = dpf_pin_in_s'(5'($urandom));
      carrier_u.drive(p);
      push(0, {7'h0, p.function_select}, 3);
      push(1, p.function_select ? {5'h0, p.clock_or_vendor_ctl, p.tdi_or_serial_rx, p.tms_or_boot}
                                : {5'h0, DPF_SCAN_IDLE}, 3);
      push(2, p.function_select ? {5'h0, DPF_ALT_IDLE}
                                : {5'h0, p.tdi_or_serial_rx, p.tms_or_boot, p.clock_or_vendor_ctl}, 3);
      push(4, {7'h0, ~p.thermal_alarm_n}, 3);
      push(6, 8'h2, 3);
      push(5, {7'h0, prev_n & ~p.thermal_alarm_n}, 3);
      prev_n = p.thermal_alarm_n;
    end
    end_test("routing");
    // Pin 1 driver in both modes, mode held steady
    for (int m = 1; m >= 0; m--) begin
      p = dpf_pin_in_s'(5'($urandom));
      p.function_select = m[0];
      carrier_u.drive(p);
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < 16; i++) begin
        @(posedge sys_clk);
        r = 3'($urandom);
        // First scan cycle drives, so the released-wire level is known
        if (m == 1 && i == 0) begin
          r[1] = 1'b1;
        end
        scan_tdo <= r[0];
        scan_tdo_en <= r[1];
        serial_tx <= r[2];
        push(3, m[0] ? {6'h0, r[0], r[1]} : {6'h0, r[2], 1'b1}, 1);
        // Released wire shows the inverse of the last driven level
        push(7, {7'h0, m[0] ? (r[1] ? r[0] : ~last_drv) : r[2]}, 1);
        last_drv = m[0] ? (r[1] ? r[0] : last_drv) : r[2];
      end
      end_test("pin1");
    end
    // Trip holds through repeated overheat until reset
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      cpu_overheat <= (i != 1);
      push(6, 8'h1, 1);
    end
    @(posedge sys_clk);
    cpu_overheat <= 1'b0;
    srst <= 1'b1;
    push(6, 8'h2, 1);
    push(0, 8'h1, 1);
    @(posedge sys_clk);
    srst <= 1'b0;
    end_test("thermal");
    wrap_up();
  end

endmodule

`default_nettype wire
